// ==== verilog/gpio_ports.v ====
/*
  four 8-bit bidirectional ports with wake-up, open drain, pull-high,
  alternate-function gating and a small register port.
  assumes synchronous pin inputs and a master that never waits.
*/
// Local design decisions: the register addresses and the strobed register port.
//
// Contract
// - direction bit one makes a pin an input, zero a CMOS output.
// - reading an output pin returns its output latch value.
// - input reads sample the pin directly, with no input latch.
// - output latches keep their value until written again.
// - reset sets all data latches and direction bits to ones.
// - pull-high is on only when selected and the pin is an input.
// - in power down a falling edge on an enabled port a pin wakes.
// - misc upper four bits make port a pins 0 to 3 open drain.
// - divider output on port a pin 3 drives only in output mode.
// - pwm on port d pins 0 to 3 drives only in output mode.
// - a timer clock pin is an input and stays readable.
// - a port b pin chosen as analog input loses its pull-high.
// - bit set and clear read the port, change a bit, write back.
`timescale 1ns/1ps
`include "gpio_defs.vh"
module gpio_ports (
  // clock and reset
  input  wire        i_mclk,
  input  wire        i_reset_n,
  // register port
  input  wire [4:0]  i_addr,
  input  wire [7:0]  i_wdata,
  input  wire        i_wr,
  input  wire        i_rd,
  output reg  [7:0]  o_rdata,
  // pads, port a in bits 7:0 up to port d in 31:24
  input  wire [31:0] i_pin,
  output wire [31:0] o_pin_out,
  output wire [31:0] o_pin_oe,
  output wire [31:0] o_pull_en,
  // shared functions
  input  wire        i_divider_out,
  input  wire [3:0]  i_pwm_out,
  input  wire [3:0]  i_pwm_en,
  output wire [3:0]  o_timer_clk_pins,
  output wire        o_ext_int_zero,
  output wire        o_ext_int_one,
  // power
  output wire        o_wakeup,
  output wire        o_irq
);
  reg  [31:0] data_reg;
  reg  [31:0] dir_reg;
  reg  [7:0]  wake_en_reg;
  reg  [7:0]  misc_reg;
  reg  [7:0]  conv_sel_reg;
  reg  [7:0]  func_en_reg;
  reg  [7:0]  ctrl_reg;
  reg  [7:0]  irq_stat_reg;
  reg  [7:0]  irq_mask_reg;
  reg  [7:0]  pa_prev_reg;
  reg  [7:0]  rdata_next;
  wire [31:0] pull_flat;
  wire [7:0]  pull_rd;
  wire [31:0] read_val;
  wire [31:0] alt_en;
  wire [31:0] alt_val;
  wire [31:0] od_sel;
  wire [31:0] analog;
  wire [7:0]  fall;
  wire        wake_evt;
  wire [7:0]  bitop_old;
  wire [7:0]  bitop_new;
  wire        bitop_wr;
  reg         pull_rd_sel_reg;

  // true when the address names a four-entry bank at base
  function in_bank;
    input [4:0] a;
    input [4:0] base;
    begin
      in_bank = (a[4:2] == base[4:2]);
    end
  endfunction

  // byte of a 32-bit word chosen by index
  function [7:0] pick;
    input [31:0] w;
    input [1:0]  idx;
    begin
      pick = w[idx*8 +: 8];
    end
  endfunction

  // pull-high bank kept in the small memory
  gpio_sync_regs u_pull (
    .i_mclk    (i_mclk),
    .i_reset_n (i_reset_n),
    .i_we      (i_wr && in_bank(i_addr, `A_PORT_PULL)),
    .i_waddr   (i_addr[1:0]),
    .i_wdata   (i_wdata),
    .i_raddr   (i_addr[1:0]),
    .o_rdata   (pull_rd),
    .o_flat    (pull_flat)
  );

  // alternate output and analog maps
  assign alt_en  = {4'h0, i_pwm_en, 20'h00000,
                    func_en_reg[`FUNC_PFD], 3'h0};
  assign alt_val = {4'h0, i_pwm_out, 20'h00000, i_divider_out, 3'h0};
  assign od_sel  = {28'h0000000, misc_reg[7:`MISC_OD_LSB]};
  assign analog  = {16'h0000, conv_sel_reg, 8'h00};

  genvar g;
  generate
    for (g = 0; g < 32; g = g + 1) begin : pins
      gpio_pin_cell u_cell (
        .i_dir        (dir_reg[g]),
        .i_latch      (data_reg[g]),
        .i_pull_sel   (pull_flat[g]),
        .i_open_drain (od_sel[g]),
        .i_alt_en     (alt_en[g]),
        .i_alt_val    (alt_val[g]),
        .i_analog     (analog[g]),
        .i_pin        (i_pin[g]),
        .o_pin_out    (o_pin_out[g]),
        .o_pin_oe     (o_pin_oe[g]),
        .o_pull_en    (o_pull_en[g]),
        .o_read       (read_val[g])
      );
    end
  endgenerate

  // timer clock pins stay ordinary readable inputs
  assign o_timer_clk_pins = i_pin[11:8];
  // external interrupts gated by their enables
  assign o_ext_int_zero = func_en_reg[`FUNC_EXTERNAL_INTERRUPT_ZERO] && i_pin[28];
  assign o_ext_int_one  = func_en_reg[`FUNC_EXTERNAL_INTERRUPT_ONE] && i_pin[29];

  // falling edge on enabled port a pins while powered down
  assign fall     = pa_prev_reg & ~i_pin[7:0] & wake_en_reg;
  assign wake_evt = ctrl_reg[`CTRL_PDOWN] && (|fall);
  assign o_wakeup = wake_evt;
  assign o_irq    = |(irq_stat_reg & irq_mask_reg);

  // bit op: whole port read, one bit changed, whole byte back
  assign bitop_old = pick(read_val, i_wdata[6:5]);
  assign bitop_new = i_wdata[`BITOP_SET] ?
                     (bitop_old | (8'h01 << i_wdata[2:0])) :
                     (bitop_old & ~(8'h01 << i_wdata[2:0]));
  assign bitop_wr  = i_wr && (i_addr == `A_BITOP);

  // register writes; latches only change on a write
  always @(posedge i_mclk) begin
    if (!i_reset_n) begin
      data_reg     <= {4{`RST_DATA}};
      dir_reg      <= {4{`RST_DIR}};
      wake_en_reg  <= `RST_ZERO;
      misc_reg     <= `RST_ZERO;
      conv_sel_reg <= `RST_ZERO;
      func_en_reg  <= `RST_ZERO;
      ctrl_reg     <= `RST_ZERO;
      irq_mask_reg <= `RST_ZERO;
      irq_stat_reg <= `RST_ZERO;
      pa_prev_reg  <= 8'hff;
    end else begin
      pa_prev_reg <= i_pin[7:0];
      if (i_wr && in_bank(i_addr, `A_PORT_DATA))
        data_reg[i_addr[1:0]*8 +: 8] <= i_wdata;
      if (i_wr && in_bank(i_addr, `A_PORT_DIR))
        dir_reg[i_addr[1:0]*8 +: 8] <= i_wdata;
      if (bitop_wr)
        data_reg[i_wdata[6:5]*8 +: 8] <= bitop_new;
      if (i_wr && i_addr == `A_WAKE_EN)
        wake_en_reg <= i_wdata;
      if (i_wr && i_addr == `A_MISC)
        misc_reg <= i_wdata;
      if (i_wr && i_addr == `A_CONV_SEL)
        conv_sel_reg <= i_wdata;
      if (i_wr && i_addr == `A_FUNC_EN)
        func_en_reg <= i_wdata;
      if (i_wr && i_addr == `A_IRQ_MASK)
        irq_mask_reg <= i_wdata;
      // wake leaves power down by itself
      if (wake_evt)
        ctrl_reg[`CTRL_PDOWN] <= 1'b0;
      else if (i_wr && i_addr == `A_CTRL)
        ctrl_reg <= i_wdata;
      // set wins over write-one-to-clear
      if (i_wr && i_addr == `A_IRQ_STAT)
        irq_stat_reg <= irq_stat_reg & ~i_wdata;
      if (wake_evt)
        irq_stat_reg[`IRQ_WAKE] <= 1'b1;
    end
  end

  // read mux; pin sampled in the strobe cycle, not held
  always @* begin
    rdata_next = 8'h00;
    if (in_bank(i_addr, `A_PORT_DATA))
      rdata_next = pick(read_val, i_addr[1:0]);
    else if (in_bank(i_addr, `A_PORT_DIR))
      rdata_next = pick(dir_reg, i_addr[1:0]);
    else begin
      case (i_addr)
        `A_WAKE_EN:  rdata_next = wake_en_reg;
        `A_MISC:     rdata_next = misc_reg;
        `A_CONV_SEL: rdata_next = conv_sel_reg;
        `A_FUNC_EN:  rdata_next = func_en_reg;
        `A_IRQ_STAT: rdata_next = irq_stat_reg;
        `A_IRQ_MASK: rdata_next = irq_mask_reg;
        `A_CTRL:     rdata_next = ctrl_reg;
        default:     rdata_next = 8'h00;
      endcase
    end
  end

  // registered read data, pull bank reads fall to the zero default
  always @(posedge i_mclk) begin
    if (!i_reset_n) begin
      o_rdata         <= 8'h00;
      pull_rd_sel_reg <= 1'b0;
    end else begin
      o_rdata         <= rdata_next;
      pull_rd_sel_reg <= i_rd && in_bank(i_addr, `A_PORT_PULL);
    end
  end
endmodule

// ==== verilog/gpio_defs.vh ====
/*
  register offsets, field positions, reset values for the four-port gpio.
  assumes inclusion by bare name from the design files.
*/
`ifndef GPIO_DEFS_VH
`define GPIO_DEFS_VH

`define ADDR_W        5
`define A_PORT_DATA   5'h00
`define A_PORT_DIR    5'h04
`define A_PORT_PULL   5'h08
`define A_WAKE_EN     5'h0c
`define A_MISC        5'h0d
`define A_CONV_SEL    5'h0e
`define A_FUNC_EN     5'h0f
`define A_IRQ_STAT    5'h10
`define A_IRQ_MASK    5'h11
`define A_BITOP       5'h12
`define A_CTRL        5'h13
`define RST_DATA      8'hff
`define RST_DIR       8'hff
`define RST_ZERO      8'h00
`define MISC_OD_LSB   4
`define FUNC_PFD      0
`define FUNC_EXTERNAL_INTERRUPT_ZERO     1
`define FUNC_EXTERNAL_INTERRUPT_ONE     2
`define CTRL_PDOWN    0
`define BITOP_SET     3
`define BITOP_PORT    4
`define IRQ_WAKE      0

`endif

// ==== verilog/gpio_sync_regs.v ====
/*
  small register bank: one byte per index, registered read data.
  assumes a single write port and single read port on i_mclk.
*/
`timescale 1ns/1ps
`include "gpio_defs.vh"
module gpio_sync_regs (
  // clock and reset
  input  wire       i_mclk,
  input  wire       i_reset_n,
  // write port
  input  wire       i_we,
  input  wire [1:0] i_waddr,
  input  wire [7:0] i_wdata,
  // read port
  input  wire [1:0] i_raddr,
  output reg  [7:0] o_rdata,
  // all words flat
  output wire [31:0] o_flat
);
  reg [7:0] mem_reg [0:3];
  integer k;

  // pull-high selects clear on reset
  always @(posedge i_mclk) begin
    if (!i_reset_n) begin
      for (k = 0; k < 4; k = k + 1)
        mem_reg[k] <= `RST_ZERO;
      o_rdata <= `RST_ZERO;
    end else begin
      if (i_we)
        mem_reg[i_waddr] <= i_wdata;
      o_rdata <= mem_reg[i_raddr];
    end
  end

  assign o_flat = {mem_reg[3], mem_reg[2], mem_reg[1], mem_reg[0]};
endmodule

// ==== verilog/gpio_pin_cell.v ====
/*
  one pin: output mux, open-drain option, pull-high and read-back select.
  assumes the pad resolves level from o_pin_oe and o_pin_out.
*/
`timescale 1ns/1ps
module gpio_pin_cell (
  // control
  input  wire i_dir,
  input  wire i_latch,
  input  wire i_pull_sel,
  input  wire i_open_drain,
  input  wire i_alt_en,
  input  wire i_alt_val,
  input  wire i_analog,
  // pad
  input  wire i_pin,
  output wire o_pin_out,
  output wire o_pin_oe,
  output wire o_pull_en,
  // read value
  output wire o_read
);
  wire drive_val;

  // alternate function only reaches the pad in output direction
  assign drive_val = i_alt_en ? i_alt_val : i_latch;
  assign o_pin_out = drive_val;
  // open drain drives only the low level
  assign o_pin_oe  = !i_dir && (!i_open_drain || !drive_val);
  // pull-high only as an input, never on an analog pin
  assign o_pull_en = i_dir && i_pull_sel && !i_analog;
  // output reads the latch, input reads the live pin unlatched
  assign o_read    = i_dir ? i_pin : i_latch;
endmodule

// ==== tb/gpio_ports_props.sv ====
/* port-level checker for gpio_ports.
   bound from the bench top file; sees top ports only. */
`timescale 1ns/1ps
module gpio_ports_props (
  // clock, reset and register port
  input wire        i_mclk,
  input wire        i_reset_n,
  input wire [4:0]  i_addr,
  input wire [7:0]  i_wdata,
  input wire        i_wr,
  input wire        i_rd,
  input wire [7:0]  o_rdata,
  // pads and shared functions
  input wire [31:0] i_pin,
  input wire [31:0] o_pin_out,
  input wire [31:0] o_pin_oe,
  input wire [31:0] o_pull_en,
  input wire [3:0]  i_pwm_out,
  input wire [3:0]  i_pwm_en,
  input wire [3:0]  o_timer_clk_pins,
  input wire        o_wakeup
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_reset_n);
  // direction byte written, then read back after one idle cycle
  sequence s_dir_wr;
    i_wr && i_addr == 5'h04;
  endsequence
  sequence s_dir_rd;
    i_rd && i_addr == 5'h04;
  endsequence
  a_dir_readback: assert property (s_dir_wr ##2 s_dir_rd |=>
    o_rdata == $past(i_wdata, 3)) else $error("dir readback wrong");
  a_pull_in_only: assert property ((o_pull_en & o_pin_oe) == 32'h0)
    else $error("pull on while driving");
  // no alternate function on these pins, so only a write moves them
  a_latch_holds: assert property (!$past(i_wr) |->
    $stable({o_pin_out[23:4], o_pin_oe[23:4]})) else $error("pad moved");
  a_unmapped_zero: assert property (i_rd && i_addr == 5'h1f |=>
    o_rdata == 8'h00) else $error("unmapped read not zero");
  a_timer_follows: assert property (o_timer_clk_pins == i_pin[11:8])
    else $error("timer pins differ");
  a_wake_on_fall: assert property (o_wakeup |->
    ($past(i_pin[7:0]) & ~i_pin[7:0]) != 8'h00) else $error("wake no fall");
  a_pwm_passes: assert property (o_pin_oe[24] && i_pwm_en[0] |->
    o_pin_out[24] == i_pwm_out[0]) else $error("pwm not on pad");
  a_reset_inputs: assert property ($rose(i_reset_n) |->
    o_pin_oe == 32'h0) else $error("pad driven after reset");
endmodule

// ==== tb/gpio_pad_model.sv ====
/* pad model: outside circuitry on all 32 port pins.
   assumes the bench picks which pins it drives from outside. */
`timescale 1ns/1ps
module gpio_pad_model (
  // float pattern clock
  input  wire        i_mclk,
  // from the port block
  input  wire [31:0] i_drive_val,
  input  wire [31:0] i_drive_en,
  input  wire [31:0] i_pull_en,
  // outside driver
  input  wire [31:0] i_ext_en,
  input  wire [31:0] i_ext_val,
  // resolved level
  output wire [31:0] o_level
);
  reg [31:0] float_reg = 32'h0;
  // undriven pins wander so a stale level never reads as valid
  always @(posedge i_mclk) float_reg <= ~float_reg;
  // chip drive wins, then outside driver, then weak pull-high
  assign o_level = (i_drive_en & i_drive_val) |
    (~i_drive_en & i_ext_en & i_ext_val) |
    (~i_drive_en & ~i_ext_en & (i_pull_en | float_reg));
endmodule

// ==== tb/gpio_ports_bench.sv ====
/* bench for gpio_ports: bus tasks, pad model, one task per test.
   assumes design, checker and pad model are compiled first. */
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin \
  error_cnt++; $display("BAD %s exp %h got %h", n, e, g); end end
module gpio_ports_bench;
  // stimulus
  reg         i_mclk = 1'b0;
  reg         i_reset_n = 1'b0;
  reg  [4:0]  i_addr = 5'h00;
  reg  [7:0]  i_wdata = 8'h00;
  reg         i_wr = 1'b0;
  reg         i_rd = 1'b0;
  reg         i_divider_out = 1'b0;
  reg  [3:0]  i_pwm_out = 4'h0;
  reg  [3:0]  i_pwm_en = 4'h0;
  reg  [31:0] ext_en = 32'hffffffff;
  reg  [31:0] ext_val = 32'h5a;
  // observed
  wire [7:0]  o_rdata;
  wire [31:0] i_pin, o_pin_out, o_pin_oe, o_pull_en;
  wire [3:0]  o_timer_clk_pins;
  wire        o_wakeup, o_irq;
  wire        o_ext_int_zero, o_ext_int_one;
  integer     error_cnt = 0;
  integer     n_compared = 0;
  integer     k;
  gpio_ports uut (.i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_pin(i_pin), .o_pin_out(o_pin_out), .o_pin_oe(o_pin_oe),
    .o_pull_en(o_pull_en), .i_divider_out(i_divider_out),
    .i_pwm_out(i_pwm_out), .i_pwm_en(i_pwm_en),
    .o_timer_clk_pins(o_timer_clk_pins), .o_ext_int_zero(o_ext_int_zero),
    .o_ext_int_one(o_ext_int_one), .o_wakeup(o_wakeup), .o_irq(o_irq));
  gpio_pad_model pads (.i_mclk(i_mclk), .i_drive_val(o_pin_out),
    .i_drive_en(o_pin_oe), .i_pull_en(o_pull_en), .i_ext_en(ext_en),
    .i_ext_val(ext_val), .o_level(i_pin));
  initial forever #50 i_mclk = ~i_mclk;
  // idle cycle after each strobe so strobes never double-assign
  task wr(input [4:0] a, input [7:0] d);
    begin
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'b1;
      @(posedge i_mclk);
      i_wr <= 1'b0;
      @(posedge i_mclk);
    end
  endtask
  task rd(input [4:0] a, input [7:0] e);
    begin
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_mclk);
      i_rd <= 1'b0;
      #1 `CHK("rdata", e, o_rdata)
      @(posedge i_mclk);
    end
  endtask
  task t_reset;
    begin
      `CHK("oe", 32'h0, o_pin_oe)
      `CHK("pull", 32'h0, o_pull_en)
      rd(5'h04, 8'hff);
      rd(5'h00, 8'h5a);
      ext_val <= 32'ha5;
      rd(5'h00, 8'ha5);
      wr(5'h07, 8'h00);
      `CHK("d out", 8'hff, o_pin_out[31:24])
      $display("done reset");
    end
  endtask
  task t_out;
    begin
      wr(5'h00, 8'h3c);
      wr(5'h04, 8'h00);
      `CHK("a out", 8'h3c, o_pin_out[7:0])
      `CHK("a oe", 8'hff, o_pin_oe[7:0])
      ext_val <= 32'h0;
      wr(5'h0d, 8'hf0);
      `CHK("od oe", 8'hf3, o_pin_oe[7:0])
      rd(5'h00, 8'h3c);
      wr(5'h0d, 8'h00);
      wr(5'h12, 8'h02);
      wr(5'h12, 8'h0f);
      rd(5'h00, 8'hb8);
      wr(5'h12, 8'h60);
      `CHK("d bitop", 8'hfe, o_pin_out[31:24])
      $display("done output");
    end
  endtask
  task t_pull;
    begin
      wr(5'h08, 8'hff);
      `CHK("pull out", 8'h00, o_pull_en[7:0])
      wr(5'h04, 8'hff);
      rd(5'h04, 8'hff);
      `CHK("pull in", 8'hff, o_pull_en[7:0])
      wr(5'h09, 8'hff);
      wr(5'h0e, 8'h0f);
      `CHK("pull b", 8'hf0, o_pull_en[15:8])
      $display("done pull");
    end
  endtask
  task t_shared;
    begin
      wr(5'h0f, 8'h01);
      `CHK("a3 in", 1'b0, o_pin_oe[3])
      wr(5'h04, 8'hf7);
      for (k = 0; k < 2; k++) begin
        i_divider_out <= k[0];
        @(posedge i_mclk);
        `CHK("a3", k[0], o_pin_out[3])
      end
      i_pwm_en <= 4'hf;
      i_pwm_out <= 4'h5;
      wr(5'h07, 8'hfc);
      `CHK("pwm", 2'b01, o_pin_out[25:24])
      `CHK("pwm oe", 4'h3, o_pin_oe[27:24])
      ext_val <= 32'h6900;
      rd(5'h01, 8'h69);
      `CHK("timer", 4'h9, o_timer_clk_pins)
      // d4 d5 high, interrupts on, then cleared before plain io use
      ext_val <= 32'h30006900;
      wr(5'h0f, 8'h07);
      `CHK("external_interrupt_zero on", 1'b1, o_ext_int_zero)
      `CHK("external_interrupt_one on", 1'b1, o_ext_int_one)
      wr(5'h0f, 8'h01);
      `CHK("external_interrupt_zero off", 1'b0, o_ext_int_zero)
      `CHK("external_interrupt_one off", 1'b0, o_ext_int_one)
      rd(5'h03, 8'h32);
      $display("done shared");
    end
  endtask
  task t_wake;
    begin
      ext_val <= 32'hff;
      wr(5'h04, 8'hff);
      wr(5'h0c, 8'h01);
      wr(5'h13, 8'h01);
      ext_val[1] <= 1'b0;
      #1 `CHK("wake off", 1'b0, o_wakeup)
      @(posedge i_mclk);
      ext_val[0] <= 1'b0;
      #1 `CHK("wake", 1'b1, o_wakeup)
      @(posedge i_mclk);
      rd(5'h13, 8'h00);
      rd(5'h10, 8'h01);
      `CHK("irq mask", 1'b0, o_irq)
      wr(5'h11, 8'h01);
      `CHK("irq", 1'b1, o_irq)
      wr(5'h10, 8'h01);
      `CHK("irq clr", 1'b0, o_irq)
      rd(5'h1f, 8'h00);
      $display("done wake");
    end
  endtask
  task wrap_up;
    begin
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) begin
        $display("[ PASS ]");
      end else begin
        $display("[ FAIL ]");
      end
      $finish;
    end
  endtask
  // whole run is under a hundred cycles
  initial begin
    repeat (5000) @(posedge i_mclk);
    error_cnt++;
    wrap_up;
  end
  initial begin
    repeat (6) @(posedge i_mclk);
    i_reset_n <= 1'b1;
    @(posedge i_mclk);
    t_reset;
    t_out;
    t_pull;
    t_shared;
    t_wake;
    wrap_up;
  end
endmodule
bind gpio_ports gpio_ports_props chk (.i_mclk(i_mclk),
  .i_reset_n(i_reset_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
  .i_rd(i_rd), .o_rdata(o_rdata), .i_pin(i_pin), .o_pin_out(o_pin_out),
  .o_pin_oe(o_pin_oe), .o_pull_en(o_pull_en), .i_pwm_out(i_pwm_out),
  .i_pwm_en(i_pwm_en), .o_timer_clk_pins(o_timer_clk_pins),
  .o_wakeup(o_wakeup));
